// *** logic/sbm_ctrl.sv ***
/*
  Control logic of the supply drop detector and supply warning monitor.
  Assumes analog comparators, a sampling strobe source, the reset
  controller and the CPU unlock guard sit outside; their pins arrive
  asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module sbm_ctrl (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      clk_en,
  input  wire sbm_pkg::sbm_req_s         req,
  output var  logic [sbm_pkg::DATA_W-1:0] rdata,
  input  wire sbm_pkg::sbm_fuse_s        detector_fuse_config,
  input  wire logic                      io_register_unlock_key,
  input  wire logic                      deep_sleep,
  input  wire logic                      debug_halt,
  input  wire logic                      sample_tick,
  input  wire logic                      supply_below_drop,
  input  wire logic                      supply_below_warn,
  output var  logic [1:0]                detector_mode,
  output var  logic                      detector_on,
  output var  logic                      sample_rate_select,
  output var  logic [2:0]                drop_threshold_select,
  output var  logic [1:0]                warning_threshold_select,
  output var  logic                      reset_request,
  output var  logic                      warning_irq,
  output var  logic                      wake_hold
);
  import sbm_pkg::*;

  // Two-flop synchronisers for all pins from other domains
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic       key_s;
  logic       sleep_s;
  logic       halt_s;
  logic       tick_s;
  logic       drop_s;
  logic       warn_s;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else if (clk_en) begin
      sync1_q <= {io_register_unlock_key, deep_sleep, debug_halt,
                  sample_tick, supply_below_drop, supply_below_warn};
      sync2_q <= sync1_q;
    end
  end

  assign {key_s, sleep_s, halt_s, tick_s, drop_s, warn_s} = sync2_q;

  // Register state
  logic       samp_q;
  logic [1:0] active_q;
  logic [1:0] sleep_q;
  logic [2:0] lvl_q;
  logic [1:0] wlvl_q;
  logic [1:0] cfg_q;
  logic       ie_q;
  logic       flag_q;
  logic       fuse_pend_q;

  function automatic logic hit(input sbm_req_s r, input logic [ADDR_W-1:0] off);
    hit = r.wr && (r.addr == off);
  endfunction

  // fuse load at reset
  // Fuses are caught on the first enabled edge after release, never
  // as an asynchronous reset value.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fuse_pend_q <= 1'b1;
      samp_q      <= 1'b0;
      active_q    <= MODE_DIS;
      sleep_q     <= MODE_DIS;
      lvl_q       <= LVL_RESET;
    end else if (clk_en) begin
      if (fuse_pend_q) begin
        fuse_pend_q <= 1'b0;
        samp_q      <= detector_fuse_config.sample_rate_select;
        active_q    <= detector_fuse_config.active_mode;
        sleep_q     <= detector_fuse_config.sleep_mode;
        lvl_q       <= detector_fuse_config.drop_threshold_select;
      end else if (hit(req, OFF_MODE_CTRL) && key_s) begin
        sleep_q <= req.wdata[SLEEP_LSB +: 2];
        samp_q  <= req.wdata[SAMP_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wlvl_q <= WLVL_OFF;
      cfg_q  <= TRIG_FALL;
      ie_q   <= 1'b0;
    end else if (clk_en) begin
      if (hit(req, OFF_MON_LEVEL)) begin
        wlvl_q <= req.wdata[1:0];
      end
      if (hit(req, OFF_MON_INTCTL)) begin
        ie_q  <= req.wdata[IE_BIT];
        cfg_q <= req.wdata[CFG_LSB +: 2];
      end
    end
  end

  // Sleep state manager
  sbm_state_e st_q;
  logic [1:0] mode_d;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q <= ST_AWAKE;
    end else if (clk_en) begin
      case (st_q)
        ST_AWAKE: begin
          if (sleep_s) begin
            st_q <= ST_ASLEEP;
          end
        end
        ST_ASLEEP: begin
          if (!sleep_s) begin
            st_q <= ST_WAKING;
          end
        end
        ST_WAKING: begin
          // One settle cycle; hold mode releases the core after it
          st_q <= ST_AWAKE;
        end
        default: begin
          st_q <= ST_AWAKE;
        end
      endcase
    end
  end

  // Mode in force; reserved sleep code treated as disabled
  always_comb begin
    mode_d = (st_q == ST_ASLEEP) ? sleep_q : active_q;
    if (st_q == ST_ASLEEP && sleep_q == MODE_HOLD) begin
      mode_d = MODE_DIS;
    end
    if (fuse_pend_q) begin
      mode_d = MODE_DIS;
    end
  end

  logic det_en;
  logic sampled;
  logic look;
  logic mon_on;
  logic [1:0] on_hist_q;
  logic [1:0] warm_q;

  // Comparator warm-up; a powered-down comparator reads junk, and the
  // result needs two synchroniser cycles before it can be trusted
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      on_hist_q <= 2'h0;
      warm_q    <= 2'h0;
    end else if (clk_en) begin
      on_hist_q <= {on_hist_q[0], detector_on};
      warm_q    <= {warm_q[0], detector_on && (warning_threshold_select != WLVL_OFF)};
    end
  end

  assign det_en  = (mode_d != MODE_DIS);
  assign sampled = (mode_d == MODE_SAMP);
  // Limitation: a sampling strobe must stay high four synced cycles
  assign look    = det_en && on_hist_q[1] && (!sampled || tick_s);

  // Held comparator results; sampled mode only refreshes on ticks
  logic drop_q;
  logic wbelow_q;
  logic wvalid_q;
  logic wprev_q;
  logic wfill_q;

  // comparison state
  // Edges count only once two trusted samples are held, except in both-edge mode, which also fires while fewer are held
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      drop_q   <= 1'b0;
      wbelow_q <= 1'b0;
      wvalid_q <= 1'b0;
      wprev_q  <= 1'b0;
      wfill_q  <= 1'b0;
    end else if (clk_en) begin
      if (!det_en) begin
        drop_q   <= 1'b0;
        wvalid_q <= 1'b0;
        wfill_q  <= 1'b0;
      end else begin
        if (look) begin
          drop_q <= drop_s;
        end
        if (!mon_on) begin
          wvalid_q <= 1'b0;
          wfill_q  <= 1'b0;
        end else if (look && warm_q[1]) begin
          wbelow_q <= warn_s;
          wprev_q  <= wbelow_q;
          wfill_q  <= 1'b1;
          wvalid_q <= wfill_q;
        end
      end
    end
  end

  logic fall_ev;
  logic rise_ev;
  logic trig;
  assign mon_on  = det_en && ie_q && (wlvl_q != WLVL_OFF);
  assign fall_ev = wbelow_q && !wprev_q;
  assign rise_ev = !wbelow_q && wprev_q;
  always_comb begin
    trig = 1'b0;
    if (look && mon_on) begin
      case (cfg_q)
        TRIG_FALL: trig = wvalid_q && fall_ev;
        TRIG_RISE: trig = wvalid_q && rise_ev;
        TRIG_BOTH: trig = !wvalid_q || fall_ev || rise_ev;
        default:   trig = 1'b0;
      endcase
    end
  end

  // write one clears
  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (trig) begin
        flag_q <= 1'b1;
      end else if (hit(req, OFF_MON_FLAGS) && req.wdata[FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= ZERO_BYTE;
    end else if (clk_en) begin
      rdata <= ZERO_BYTE;
      if (req.rd) begin
        case (req.addr)
          OFF_MODE_CTRL:  rdata <= {3'h0, samp_q, active_q, sleep_q};
          OFF_THRESH_LVL: rdata <= {5'h00, lvl_q};
          OFF_MON_LEVEL:  rdata <= {6'h00, wlvl_q};
          OFF_MON_INTCTL: rdata <= {5'h00, cfg_q, ie_q};
          OFF_MON_FLAGS:  rdata <= {7'h00, flag_q};
          OFF_MON_STATE:  rdata <= {7'h00, wbelow_q};
          default:        rdata <= ZERO_BYTE;
        endcase
      end
    end
  end

  // Registered outputs
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      detector_mode            <= MODE_DIS;
      detector_on              <= 1'b0;
      sample_rate_select       <= 1'b0;
      drop_threshold_select    <= LVL_RESET;
      warning_threshold_select <= WLVL_OFF;
      reset_request            <= 1'b0;
      warning_irq              <= 1'b0;
      wake_hold                <= 1'b0;
    end else if (clk_en) begin
      detector_mode            <= mode_d;
      detector_on              <= det_en && (!sampled || tick_s);
      sample_rate_select       <= samp_q;
      drop_threshold_select    <= lvl_q;
      warning_threshold_select <= mon_on ? wlvl_q : WLVL_OFF;
      reset_request            <= drop_q;
      warning_irq              <= ie_q && flag_q && !halt_s;
      wake_hold                <= (st_q == ST_WAKING) && (active_q == MODE_HOLD);
    end
  end
endmodule
`default_nettype wire

// *** logic/sbm_pkg.sv ***
/*
  Package for the supply drop detector and supply warning monitor control.
  Holds register offsets, field positions, mode encodings and bus structs.
  Assumes an 8-bit register port with one-cycle strobes.
*/
package sbm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_MODE_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_THRESH_LVL = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_MON_LEVEL  = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_MON_INTCTL = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_MON_FLAGS  = 4'ha;
  localparam logic [ADDR_W-1:0] OFF_MON_STATE  = 4'hb;

  // Field positions in detector_mode_control
  localparam int SLEEP_LSB = 0;
  localparam int ACTIVE_LSB = 2;
  localparam int SAMP_BIT = 4;
  // Field positions in monitor_interrupt_control, monitor flags and monitor state
  localparam int IE_BIT = 0;
  localparam int CFG_LSB = 1;
  localparam int FLAG_BIT = 0;
  localparam int STATE_BIT = 0;

  // Detector operating modes
  localparam logic [1:0] MODE_DIS  = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_SAMP = 2'h2;
  localparam logic [1:0] MODE_HOLD = 2'h3;

  // Warning trigger selection
  localparam logic [1:0] TRIG_FALL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_BOTH = 2'h2;

  // Warning threshold selection
  localparam logic [1:0] WLVL_OFF = 2'h0;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] LVL_RESET = 3'h0;

  // Fuse image loaded at reset
  typedef struct packed {
    logic       sample_rate_select;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] drop_threshold_select;
  } sbm_fuse_s;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sbm_req_s;

  // Detector state manager
  typedef enum logic [1:0] {ST_AWAKE, ST_ASLEEP, ST_WAKING} sbm_state_e;
endpackage

// *** tb/sbm_ctrl_asserts.sv ***
/* Port checks for sbm_ctrl, bound into every instance.
   Assumes one clock and a synchronous active low reset. */
`timescale 1ns/1ps
`default_nettype none
module sbm_ctrl_asserts (
  input wire logic                       mclk,
  input wire logic                       rstn,
  input wire logic                       clk_en,
  input wire sbm_pkg::sbm_req_s          req,
  input wire logic [sbm_pkg::DATA_W-1:0] rdata,
  input wire sbm_pkg::sbm_fuse_s         detector_fuse_config,
  input wire logic                       io_register_unlock_key,
  input wire logic                       deep_sleep,
  input wire logic                       debug_halt,
  input wire logic                       sample_tick,
  input wire logic                       supply_below_drop,
  input wire logic                       supply_below_warn,
  input wire logic [1:0]                 detector_mode,
  input wire logic                       detector_on,
  input wire logic                       sample_rate_select,
  input wire logic [2:0]                 drop_threshold_select,
  input wire logic [1:0]                 warning_threshold_select,
  input wire logic                       reset_request,
  input wire logic                       warning_irq,
  input wire logic                       wake_hold
);
  import sbm_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Enable cleared by software, then a quiet cycle
  sequence s_ie_off;
    req.wr && clk_en && req.addr == OFF_MON_INTCTL && !req.wdata[IE_BIT];
  endsequence
  sequence s_quiet;
    clk_en && !req.wr;
  endsequence
  // Six cycles of margin cover the two-flop synchronisers
  a_drop_resets: assert property (
    (supply_below_drop && clk_en && detector_mode[0])[*6] |-> reset_request)
    else $error("reset not requested on drop");
  a_no_false_reset: assert property (
    (!supply_below_drop && clk_en && detector_mode[0])[*6] |-> !reset_request)
    else $error("reset requested with good supply");
  a_ie_off_irq: assert property (
    s_ie_off ##1 s_quiet |=> !warning_irq)
    else $error("irq stays after enable cleared");
  a_debug_mask: assert property (
    (debug_halt && clk_en)[*5] |-> !warning_irq)
    else $error("irq during debug halt");
  a_level_fixed: assert property (
    ($past(rstn) && $past(rstn, 2) && $past(rstn, 3)) |-> $stable(drop_threshold_select))
    else $error("drop level changed after load");
  a_awake_mode: assert property (
    (!deep_sleep && clk_en)[*6] |-> $stable(detector_mode))
    else $error("awake mode changed");
  a_sleep_mode: assert property (
    (deep_sleep && clk_en)[*6] |-> detector_mode != MODE_HOLD)
    else $error("sleep mode uses wake hold");
  a_off_idle: assert property (
    (detector_mode == MODE_DIS)[*3] |-> !detector_on && !reset_request)
    else $error("disabled detector active");
  a_cont_on: assert property (
    (detector_mode[0])[*3] |-> detector_on)
    else $error("continuous detector off");
  a_wake_pulse: assert property (
    wake_hold && clk_en |=> !wake_hold)
    else $error("wake hold longer than a cycle");
endmodule
bind sbm_ctrl sbm_ctrl_asserts u_chk (
  .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .req(req), .rdata(rdata),
  .detector_fuse_config(detector_fuse_config),
  .io_register_unlock_key(io_register_unlock_key), .deep_sleep(deep_sleep),
  .debug_halt(debug_halt), .sample_tick(sample_tick),
  .supply_below_drop(supply_below_drop), .supply_below_warn(supply_below_warn),
  .detector_mode(detector_mode), .detector_on(detector_on),
  .sample_rate_select(sample_rate_select),
  .drop_threshold_select(drop_threshold_select),
  .warning_threshold_select(warning_threshold_select),
  .reset_request(reset_request), .warning_irq(warning_irq), .wake_hold(wake_hold));
`default_nettype wire

// *** tb/sbm_supply_model.sv ***
/* Comparator pair of the supply drop detector and warning monitor.
   Assumes volt in arbitrary steps, mclk free running. */
`timescale 1ns/1ps
`default_nettype none
module sbm_supply_model (
  input  wire logic       mclk,
  input  wire logic       detector_on,
  input  wire logic [2:0] drop_threshold_select,
  input  wire logic [1:0] warning_threshold_select,
  input  wire logic [7:0] volt,
  output var logic        supply_below_drop,
  output var logic        supply_below_warn
);
  int   drop_t;
  int   warn_t;
  int   pct [4] = '{0, 5, 15, 25};
  logic junk_q = 1'b0;
  // warning level sits a percentage above the drop level
  always_comb begin
    drop_t = 40 + 8 * drop_threshold_select;
    warn_t = drop_t + drop_t * pct[warning_threshold_select] / 100;
  end
  // Powered-down comparator output is junk, so it flips every cycle
  always_ff @(posedge mclk) junk_q <= !junk_q;
  assign supply_below_drop = detector_on ? (volt < drop_t) : junk_q;
  assign supply_below_warn = (detector_on && warning_threshold_select != 2'h0)
                             ? (volt < warn_t) : junk_q;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/* Self-checking bench for sbm_ctrl with the comparator model.
   Assumes package, design, model and checker compile first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  import sbm_pkg::*;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic       clk_en = 1'b1;
  sbm_req_s   req = '0;
  sbm_fuse_s  fuse = '0;
  logic       key = 1'b0;
  logic       deep_sleep = 1'b0;
  logic       debug_halt = 1'b0;
  logic       sample_tick = 1'b0;
  logic [4:0] tick_cnt = '0;
  logic [7:0] volt = 8'd100;
  logic [7:0] rdata;
  logic [7:0] exp_v;
  logic [7:0] exp_q [$];
  logic       rd_seen = 1'b0;
  logic       drop, warn, d_on, ssel, rst_req, irq, whold;
  logic [1:0] dmode, wsel;
  logic [2:0] dsel;
  logic       seen;
  logic [31:0] lfsr = 32'h0000_06d2;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         on_cnt;
  sbm_ctrl uut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .req(req), .rdata(rdata),
    .detector_fuse_config(fuse), .io_register_unlock_key(key), .deep_sleep(deep_sleep),
    .debug_halt(debug_halt), .sample_tick(sample_tick), .supply_below_drop(drop),
    .supply_below_warn(warn), .detector_mode(dmode), .detector_on(d_on),
    .sample_rate_select(ssel), .drop_threshold_select(dsel),
    .warning_threshold_select(wsel), .reset_request(rst_req), .warning_irq(irq),
    .wake_hold(whold));
  sbm_supply_model u_model (.mclk(mclk), .detector_on(d_on), .drop_threshold_select(dsel),
    .warning_threshold_select(wsel), .volt(volt), .supply_below_drop(drop),
    .supply_below_warn(warn));
  initial forever #25 mclk = ~mclk;
  // Sampling strobe, four cycles high out of thirty-two
  always @(posedge mclk) begin
    tick_cnt <= tick_cnt + 5'h01;
    sample_tick <= (tick_cnt[4:2] == 3'h0);
  end
  // Read data is only valid the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
    rd_seen <= req.rd && clk_en;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    req.rd <= 1'b0;
  endtask
  task automatic do_reset(input logic [7:0] f);
    @(posedge mclk);
    rstn <= 1'b0;
    fuse <= f;
    tick(4);
    rstn <= 1'b1;
    tick(2);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  initial begin
    tick(5000);
    fail_count++;
    stop_test();
  end
  // Main sequence; the fuse pin moves after load and must not be reloaded
  initial begin
    do_reset(8'h6a);
    fuse <= 8'h05;
    rd(OFF_MODE_CTRL, 8'h0d);
    rd(OFF_THRESH_LVL, 8'h02);
    wr(OFF_MODE_CTRL, 8'h00);
    rd(OFF_MODE_CTRL, 8'h0d);
    // key window opens before the guarded write
    key <= 1'b1;
    tick(4);
    wr(OFF_MODE_CTRL, 8'h12);
    key <= 1'b0;
    rd(OFF_MODE_CTRL, 8'h1e);
    `CHK(ssel, 1'b1)
    wr(OFF_THRESH_LVL, 8'hff);
    rd(OFF_THRESH_LVL, 8'h02);
    rd(4'h3, 8'h00);
    wr(OFF_MON_INTCTL, 8'h01);
    for (int c = 0; c < 4; c++) begin
      lfsr = lfsr_next(lfsr);
      wr(OFF_MON_LEVEL, {lfsr[7:2], c[1:0]});
      rd(OFF_MON_LEVEL, {6'h00, c[1:0]});
      `CHK(wsel, c[1:0])
    end
    for (int c = 0; c < 3; c++) begin
      wr(OFF_MON_INTCTL, 8'h00);
      wr(OFF_MON_FLAGS, 8'h01);
      wr(OFF_MON_INTCTL, {5'h00, c[1:0], 1'b1});
      tick(4);
      rd(OFF_MON_FLAGS, {7'h00, c == 2});
      wr(OFF_MON_FLAGS, 8'h01);
      volt <= 8'd63;
      tick(8);
      `CHK(rst_req, 1'b0)
      rd(OFF_MON_STATE, 8'h01);
      rd(OFF_MON_FLAGS, {7'h00, c != 1});
      wr(OFF_MON_FLAGS, 8'h01);
      volt <= 8'd100;
      tick(8);
      rd(OFF_MON_STATE, 8'h00);
      rd(OFF_MON_FLAGS, {7'h00, c != 0});
    end
    `CHK(irq, 1'b1)
    debug_halt <= 1'b1;
    tick(6);
    `CHK(irq, 1'b0)
    debug_halt <= 1'b0;
    tick(6);
    `CHK(irq, 1'b1)
    wr(OFF_MON_FLAGS, 8'h00);
    rd(OFF_MON_FLAGS, 8'h01);
    wr(OFF_MON_FLAGS, 8'h01);
    tick(3);
    `CHK(irq, 1'b0)
    volt <= 8'd30;
    tick(8);
    `CHK(rst_req, 1'b1)
    volt <= 8'd100;
    tick(8);
    `CHK(rst_req, 1'b0)
    deep_sleep <= 1'b1;
    tick(6);
    `CHK(dmode, MODE_SAMP)
    on_cnt = 0;
    repeat (64) begin
      @(posedge mclk);
      on_cnt += d_on;
    end
    `CHK(on_cnt > 0 && on_cnt < 64, 1'b1)
    deep_sleep <= 1'b0;
    seen = 1'b0;
    repeat (8) begin
      @(posedge mclk);
      seen |= whold;
    end
    `CHK(seen, 1'b1)
    `CHK(dmode, MODE_HOLD)
    // Frozen clock enable must drop the write
    clk_en <= 1'b0;
    wr(OFF_MON_LEVEL, 8'h01);
    clk_en <= 1'b1;
    rd(OFF_MON_LEVEL, 8'h03);
    do_reset(8'h05);
    rd(OFF_THRESH_LVL, 8'h05);
    rd(OFF_MODE_CTRL, 8'h00);
    wr(OFF_MON_LEVEL, 8'h03);
    wr(OFF_MON_INTCTL, 8'h05);
    volt <= 8'd30;
    tick(10);
    `CHK(rst_req, 1'b0)
    `CHK(d_on, 1'b0)
    rd(OFF_MON_FLAGS, 8'h00);
    tick(3);
    stop_test();
  end
endmodule
`default_nettype wire
